//--- verilog/pin_ctrl_consts.svh
`ifndef PIN_CTRL_CONSTS_SVH
`define PIN_CTRL_CONSTS_SVH

// Clock period in nanoseconds and reset hold time.
`define CLK_PERIOD_NS     100
`define RESET_HOLD_NS     2000
// Last count of the clear filter. The reset follows one edge later, so a
// low held longer than the hold time is caught whatever its phase.
`define RESET_HOLD_CYC    (`RESET_HOLD_NS / `CLK_PERIOD_NS - 1)
`define RATE_FIXED_LOW    32'd9600
`define RATE_DEFAULT_HIGH 32'd38400
`define LAMP_STEP_CYC     16'h0004
`define LAMP_STEPS        3'h4
`define IND_OFF           4'hF

`endif

//--- verilog/pin_ctrl_pkg.sv
package pin_ctrl_pkg;

    typedef struct packed {
        logic host_rx;
        logic host_tx;
        logic veh_rx;
        logic veh_tx;
    } activity_t;

    typedef struct packed {
        logic baud_high;
        logic store_en;
        logic newline_en;
    } straps_t;

    typedef enum logic [1:0] {
        PROTO_VPW = 2'b00,
        PROTO_PWM = 2'b01,
        PROTO_ISO = 2'b10,
        PROTO_CAN = 2'b11
    } proto_t;

endpackage

//--- verilog/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RESET_VAL;
            q_o    <= RESET_VAL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

//--- verilog/diag_bridge_pin_control.sv
`timescale 1ns/1ps
`include "pin_ctrl_consts.svh"

// How it works
// R1: Baud strap high picks 38400 or stored rate; low forces 9600.
// R2: Memory strap sets default state of the store option.
// R3: Store on and off commands change the option at any time; the code ignores them in reset and in the cycle that loads the strap defaults.
// R4: Line-end strap high gives CR plus LF, low gives CR only.
// R5: Newline on and off commands override the line-end default.
// R6: Reset input held low beyond 2 us causes a full reset.
// R7: Supply select high for VPW 8V, low for PWM 5V.
// R8: Positive bus drive high forces positive line active.
// R9: VPW receive input is active high; low means idle.
// R10: K-line receive input is active low; high means idle.
// R11: PWM receive input is active low; high means idle.
// R12: In PWM mode negative bus drive high forces line dominant.
// R13: K and L outputs high force ISO bus dominant.
// R14: Request-to-send low abandons bus work to take a command.
// R15: Host holds request-to-send low until busy goes low.
// R16: Busy high while processing, low when ready for characters.
// R17: Serial transmit output idles high.
// R18: Host keeps serial receive input high when idle.
// R19: Four activity indicators idle high, low during transfers.
// R20: Vehicle transmit indicator pin read as input disables stored parameters.
// R21: Host link frames are 8 data bits, no parity, 1 stop.
// R22: After reset the indicators light one by one as a lamp test.
// R23: Host ends messages with carriage return before action.
// R24: Straps are captured once at reset release and held.
// R25: Request-to-send and bus inputs pass two flip-flop stages.
module diag_bridge_pin_control
    import pin_ctrl_pkg::*;
#(
    parameter int          RESET_HOLD_CYC = `RESET_HOLD_CYC,
    parameter logic [31:0] STORED_RATE    = `RATE_DEFAULT_HIGH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        master_clear_n_i,
    input  wire logic        baud_strap_i,
    input  wire logic        memory_strap_i,
    input  wire logic        line_end_strap_i,
    input  wire logic [31:0] stored_rate_param_i,
    input  wire logic        stored_rate_valid_i,
    input  wire logic        store_on_cmd_i,
    input  wire logic        store_off_cmd_i,
    input  wire logic        newline_on_cmd_i,
    input  wire logic        newline_off_cmd_i,
    input  wire proto_t      proto_i,
    input  wire logic        bus_active_i,
    input  wire logic        core_busy_i,
    input  wire logic        tx_bit_i,
    input  wire logic        tx_active_i,
    input  wire activity_t   activity_i,
    input  wire logic        request_to_send_n_i,
    input  wire logic        variable_pulse_rx_i,
    input  wire logic        kline_rx_n_i,
    input  wire logic        pwm_rx_n_i,
    input  wire logic        vehicle_tx_indicator_n_i,
    output logic             sys_reset_o,
    output logic [31:0]      host_baud_o,
    output logic             store_en_o,
    output logic             newline_en_o,
    output logic             params_disabled_o,
    output logic             abort_o,
    output logic             bus_supply_select_o,
    output logic             pos_bus_drive_o,
    output logic             neg_bus_drive_o,
    output logic             kline_drive_o,
    output logic             lline_drive_o,
    output logic             vpw_bus_active_o,
    output logic             kline_bus_active_o,
    output logic             pwm_bus_active_o,
    output logic             busy_o,
    output logic             host_serial_out_o,
    output logic             lamp_test_o,
    output activity_t        indicator_n_o,
    output logic             vehicle_tx_indicator_n_oe_o
);

    // ****************************************************************
    // Reset filter and strap capture
    // ****************************************************************
    logic [15:0] clr_cnt_r;
    logic        clr_rst_r;
    logic        sys_rst;
    logic        sys_rst_d_r;
    straps_t     strap_r;
    logic        store_r;
    logic        newline_r;
    logic        pdis_r;
    logic        pdis_q;
    logic [15:0] hold_max;

    assign hold_max = 16'(RESET_HOLD_CYC);
    assign sys_rst  = rst_i | clr_rst_r;

    // A short glitch on the clear pin is filtered, only a full hold resets.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clr_cnt_r <= 16'h0000;
            clr_rst_r <= 1'b0;
        end else if (master_clear_n_i) begin
            clr_cnt_r <= 16'h0000;
            clr_rst_r <= 1'b0;
        end else if (clr_cnt_r < hold_max) begin
            clr_cnt_r <= clr_cnt_r + 16'h0001;
        end else begin
            clr_rst_r <= 1'b1; // R6
        end
    end
    assign sys_reset_o = sys_rst;

    // Capturing on the release edge ignores strap bounce afterwards.
    always_ff @(posedge clk_i) begin
        sys_rst_d_r <= sys_rst;
        if (sys_rst_d_r && !sys_rst) begin
            strap_r.baud_high  <= baud_strap_i;     // R1 R24
            strap_r.store_en   <= memory_strap_i;   // R2 R24
            strap_r.newline_en <= line_end_strap_i; // R4 R24
            pdis_r             <= pdis_q;           // R20
        end
    end

    sync2 #(.RESET_VAL(1'b1)) u_pdis (
        .clk_i (clk_i),
        .rst_i (1'b0),
        .d_i   (vehicle_tx_indicator_n_i),
        .q_o   (pdis_q)
    );

    // ****************************************************************
    // Option flags
    // ****************************************************************
    logic opts_load_r;
    always_ff @(posedge clk_i) begin
        opts_load_r <= sys_rst_d_r && !sys_rst;
        if (sys_rst) begin
            store_r   <= 1'b0;
            newline_r <= 1'b0;
        end else if (opts_load_r) begin
            store_r   <= strap_r.store_en;
            newline_r <= strap_r.newline_en;
        end else begin
            if (store_on_cmd_i)
                store_r <= 1'b1;      // R3
            else if (store_off_cmd_i)
                store_r <= 1'b0;      // R3
            if (newline_on_cmd_i)
                newline_r <= 1'b1;    // R5
            else if (newline_off_cmd_i)
                newline_r <= 1'b0;    // R5
        end
    end
    assign store_en_o        = store_r;
    assign newline_en_o      = newline_r;
    assign params_disabled_o = ~pdis_r; // R20

    wire use_stored = stored_rate_valid_i & pdis_r;
    assign host_baud_o = !strap_r.baud_high ? `RATE_FIXED_LOW :
                         (use_stored ? stored_rate_param_i
                                     : STORED_RATE); // R1

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic rts_n_q;
    logic vpw_q;
    logic kln_n_q;
    logic pwm_n_q;

    sync2 #(.RESET_VAL(1'b1)) u_rts (
        .clk_i (clk_i),
        .rst_i (sys_rst),
        .d_i   (request_to_send_n_i),
        .q_o   (rts_n_q)                           // R25
    );
    sync2 #(.RESET_VAL(1'b0)) u_vpw (
        .clk_i (clk_i),
        .rst_i (sys_rst),
        .d_i   (variable_pulse_rx_i),
        .q_o   (vpw_q)                             // R25
    );
    sync2 #(.RESET_VAL(1'b1)) u_kln (
        .clk_i (clk_i),
        .rst_i (sys_rst),
        .d_i   (kline_rx_n_i),
        .q_o   (kln_n_q)                           // R25
    );
    sync2 #(.RESET_VAL(1'b1)) u_pwm (
        .clk_i (clk_i),
        .rst_i (sys_rst),
        .d_i   (pwm_rx_n_i),
        .q_o   (pwm_n_q)                           // R25
    );

    assign vpw_bus_active_o   = vpw_q;    // R9
    assign kline_bus_active_o = ~kln_n_q; // R10
    assign pwm_bus_active_o   = ~pwm_n_q; // R11

    // ****************************************************************
    // Bus drivers, abort and busy
    // ****************************************************************
    logic rts_d_r;
    logic abort_r;
    logic lamp_on;
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            rts_d_r <= 1'b1;
            abort_r <= 1'b0;
        end else begin
            rts_d_r <= rts_n_q;
            abort_r <= rts_d_r & ~rts_n_q; // R14
        end
    end
    assign abort_o = abort_r;

    wire drive_ok = bus_active_i & ~abort_r & ~lamp_on & ~sys_rst;
    assign bus_supply_select_o = (proto_i == PROTO_VPW);     // R7
    assign pos_bus_drive_o = drive_ok &
        ((proto_i == PROTO_VPW) | (proto_i == PROTO_PWM)); // R8
    assign neg_bus_drive_o = drive_ok & (proto_i == PROTO_PWM); // R12
    assign kline_drive_o   = drive_ok & (proto_i == PROTO_ISO); // R13
    assign lline_drive_o   = drive_ok & (proto_i == PROTO_ISO); // R13

    // Busy stays high through lamp test so the host waits for it.
    assign busy_o = sys_rst | lamp_on | (core_busy_i & ~abort_r); // R16
    // R17 R21: the serialiser sends 8N1 frames; idle is held high here.
    assign host_serial_out_o = tx_active_i ? tx_bit_i : 1'b1; // R17

    // ****************************************************************
    // Lamp test sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        LT_RUN  = 3'b001,
        LT_DONE = 3'b010,
        LT_IDLE = 3'b100
    } lamp_state_t;

    lamp_state_t lt_r;
    lamp_state_t lt_nxt;
    logic [15:0] step_cnt_r;
    logic [2:0]  step_r;
    wire         step_end = (step_cnt_r == `LAMP_STEP_CYC - 16'h0001);
    wire         last     = (step_r == `LAMP_STEPS - 3'h1);

    always_comb begin
        lt_nxt = lt_r;
        case (lt_r)
            LT_IDLE: lt_nxt = LT_RUN;
            LT_RUN:  if (step_end && last) lt_nxt = LT_DONE;
            LT_DONE: lt_nxt = LT_DONE;
            default: lt_nxt = LT_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            lt_r       <= LT_IDLE;
            step_cnt_r <= 16'h0000;
            step_r     <= 3'h0;
        end else begin
            lt_r <= lt_nxt;
            if (lt_r == LT_RUN) begin
                step_cnt_r <= step_end ? 16'h0000 : step_cnt_r + 16'h0001;
                if (step_end)
                    step_r <= step_r + 3'h1; // R22
            end
        end
    end
    assign lamp_on     = (lt_r != LT_DONE);
    assign lamp_test_o = lamp_on;

    // ****************************************************************
    // Indicators
    // ****************************************************************
    logic [3:0] lamp_pat;
    activity_t  ind_r;
    assign lamp_pat = (lt_r == LT_RUN) ? ~(4'h8 >> step_r[1:0]) : `IND_OFF;

    always_ff @(posedge clk_i) begin
        if (sys_rst)
            ind_r <= `IND_OFF;
        else if (lamp_on)
            ind_r <= lamp_pat;            // R22
        else
            ind_r <= ~activity_i;         // R19
    end
    assign indicator_n_o = ind_r;
    // The vehicle transmit lamp pin is released during reset so it can
    // be read as the parameter-disable input.
    assign vehicle_tx_indicator_n_oe_o = ~sys_rst; // R20

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_BAUD_LOW: assert property (@(posedge clk_i) disable iff (sys_rst) // R1
        !strap_r.baud_high |-> host_baud_o == `RATE_FIXED_LOW)
        else $error("baud not fixed low");
    AST_STRAP_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst) // R24
        sys_rst_d_r == 1'b0 |=> $stable(strap_r))
        else $error("strap changed");
    AST_STORE_ON: assert property (@(posedge clk_i) disable iff (sys_rst) // R3
        store_on_cmd_i && !opts_load_r |=> store_en_o)
        else $error("store on lost");
    AST_NL_OFF: assert property (@(posedge clk_i) disable iff (sys_rst) // R5
        newline_off_cmd_i && !newline_on_cmd_i && !opts_load_r
        |=> !newline_en_o)
        else $error("newline off lost");
    AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        !master_clear_n_i && clr_cnt_r == hold_max |=> sys_reset_o)
        else $error("clear did not reset");
    AST_NEG: assert property (@(posedge clk_i) // R12
        neg_bus_drive_o |-> proto_i == PROTO_PWM)
        else $error("neg drive outside PWM");
    AST_ABORT: assert property (@(posedge clk_i) disable iff (sys_rst) // R14
        $fell(rts_n_q) |=> abort_o)
        else $error("no abort on rts");
    AST_TX_IDLE: assert property (@(posedge clk_i) // R17
        !tx_active_i |-> host_serial_out_o)
        else $error("tx not idle high");
    AST_IND: assert property (@(posedge clk_i) disable iff (sys_rst) // R19
        !lamp_on && !$past(lamp_on) |-> indicator_n_o == ~$past(activity_i))
        else $error("indicator mismatch");
    COV_LAMP: cover property (@(posedge clk_i) $fell(lamp_on));
    COV_ABORT: cover property (@(posedge clk_i) abort_o);
    COV_CLR: cover property (@(posedge clk_i) $rose(clr_rst_r));
endmodule

//--- sim/host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_i,
    input  wire logic busy_i,
    output logic      rts_n_o,
    output logic      serial_o
);
    // ****************************************
    // Host side of the handshake
    // ****************************************
    initial rts_n_o = 1'b1;
    initial serial_o = 1'b1;
    // Sends one 8N1 character, one bit per clock, and ends on the stop bit
    // so the line is left at its idle level.
    task send_char(input logic [7:0] ch);
        int         b;
        logic [9:0] frame;
        begin
            frame = {1'b1, ch, 1'b0};
            for (b = 0; b < 10; b++) begin
                @(posedge clk_i);
                serial_o <= frame[b];
            end
        end
    endtask
    // Holds the request low for at least four edges, then until busy
    // drops or 100 more edges pass, so a device ready within that is never left with a half-seen request.
    task attention(input int extra, output int waited);
        begin
            waited = 0;
            @(posedge clk_i);
            rts_n_o <= 1'b0;
            repeat (4 + extra) @(posedge clk_i);
            while (busy_i !== 1'b0 && waited < 100) begin
                @(posedge clk_i);
                waited++;
            end
            rts_n_o <= 1'b1;
        end
    endtask
endmodule

//--- sim/diag_bridge_pin_control_bench.sv
`timescale 1ns/1ps
module diag_bridge_pin_control_bench
    import pin_ctrl_pkg::*;
;
    // ****************************************
    // Stimulus, model state and design
    // ****************************************
    logic clk_i, rst_i, master_clear_n_i, baud_strap_i, memory_strap_i;
    logic line_end_strap_i, stored_rate_valid_i, store_on_cmd_i;
    logic store_off_cmd_i, newline_on_cmd_i, newline_off_cmd_i;
    logic bus_active_i, core_busy_i, tx_bit_i, tx_active_i;
    logic request_to_send_n_i, variable_pulse_rx_i, kline_rx_n_i;
    logic pwm_rx_n_i, vehicle_tx_indicator_n_i;
    logic [31:0] stored_rate_param_i, host_baud_o;
    proto_t proto_i;
    activity_t activity_i, indicator_n_o;
    logic sys_reset_o, store_en_o, newline_en_o, params_disabled_o, abort_o;
    logic bus_supply_select_o, pos_bus_drive_o, neg_bus_drive_o;
    logic kline_drive_o, lline_drive_o, vpw_bus_active_o;
    logic kline_bus_active_o, pwm_bus_active_o, busy_o, host_serial_out_o;
    logic lamp_test_o, vehicle_tx_indicator_n_oe_o;
    logic [3:0] lamp_seen;
    logic [3:0] cmd_tab [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC, 4'h3};
    int err_count, checks_done, seed, i, w, abort_cnt, rst_cnt;
    logic e_bs, e_ms, e_ls, e_v, e_val;
    logic host_line;

    diag_bridge_pin_control #(.RESET_HOLD_CYC(5)) diag_bridge_pin_control_inst (
        .clk_i, .rst_i, .master_clear_n_i, .baud_strap_i, .memory_strap_i,
        .line_end_strap_i, .stored_rate_param_i, .stored_rate_valid_i,
        .store_on_cmd_i, .store_off_cmd_i, .newline_on_cmd_i,
        .newline_off_cmd_i, .proto_i, .bus_active_i, .core_busy_i,
        .tx_bit_i, .tx_active_i, .activity_i, .request_to_send_n_i,
        .variable_pulse_rx_i, .kline_rx_n_i, .pwm_rx_n_i,
        .vehicle_tx_indicator_n_i, .sys_reset_o, .host_baud_o, .store_en_o,
        .newline_en_o, .params_disabled_o, .abort_o, .bus_supply_select_o,
        .pos_bus_drive_o, .neg_bus_drive_o, .kline_drive_o, .lline_drive_o,
        .vpw_bus_active_o, .kline_bus_active_o, .pwm_bus_active_o, .busy_o,
        .host_serial_out_o, .lamp_test_o, .indicator_n_o,
        .vehicle_tx_indicator_n_oe_o);
    host_model host_model_inst (.clk_i(clk_i), .busy_i(busy_o),
        .rts_n_o(request_to_send_n_i), .serial_o(host_line));

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (abort_o === 1'b1) abort_cnt++;
        if (sys_reset_o === 1'b1) rst_cnt++;
        if (sys_reset_o === 1'b1) lamp_seen <= 4'h0;
        else if (lamp_test_o === 1'b1)
            lamp_seen <= lamp_seen | ~4'(indicator_n_o);
    end

    task check(input string what, input logic [31:0] seen, exp);
        begin
            checks_done++;
            if (seen !== exp) begin
                err_count++;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task test_done();
        begin
            $display("checks %0d errors %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task wait_ready();
        int n;
        begin
            n = 0;
            @(negedge clk_i);
            while (busy_o !== 1'b0 && n < 200) begin
                @(negedge clk_i);
                n++;
            end
            check("ready after reset", n < 200, 1);
        end
    endtask

    task check_straps();
        begin
            check("params_disabled", params_disabled_o, !e_v);
            check("store_en", store_en_o, e_ms);
            check("newline_en", newline_en_o, e_ls);
            check("host_baud", host_baud_o, !e_bs ? 9600 :
                (e_val && e_v) ? stored_rate_param_i : 38400);
        end
    endtask

    // A fresh strap pattern per reset covers every captured default.
    task do_reset();
        begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            {e_bs, e_ms, e_ls, e_v, e_val} = 5'($random(seed));
            {baud_strap_i, memory_strap_i, line_end_strap_i} <= 3'({e_bs, e_ms, e_ls});
            vehicle_tx_indicator_n_i <= 1'(e_v);
            stored_rate_valid_i <= 1'(e_val);
            stored_rate_param_i <= $random(seed);
            repeat (5) @(posedge clk_i);
            rst_i <= 1'b0;
            wait_ready();
            check("lamp test", lamp_seen, 4'hF);
            check_straps();
        end
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        seed = 73257;
        master_clear_n_i = 1'b1;
        {store_on_cmd_i, store_off_cmd_i, newline_on_cmd_i} = 3'h0;
        {newline_off_cmd_i, bus_active_i, core_busy_i, tx_bit_i} = 4'h0;
        {tx_active_i, variable_pulse_rx_i, kline_rx_n_i, pwm_rx_n_i} = 4'h3;
        proto_i = PROTO_VPW;
        activity_i = 4'h0;
        for (i = 0; i < 4; i++) begin
            do_reset();
            @(posedge clk_i);
            {baud_strap_i, memory_strap_i, line_end_strap_i} <= 3'(~{e_bs, e_ms, e_ls});
            repeat (3) @(negedge clk_i);
            check_straps();
            @(posedge clk_i);
            {baud_strap_i, memory_strap_i, line_end_strap_i} <= 3'({e_bs, e_ms, e_ls});
        end
        for (i = 0; i < 6; i++) begin
            @(posedge clk_i);
            {store_on_cmd_i, store_off_cmd_i, newline_on_cmd_i, newline_off_cmd_i} <= cmd_tab[i];
            @(posedge clk_i);
            {store_on_cmd_i, store_off_cmd_i, newline_on_cmd_i, newline_off_cmd_i} <= 4'h0;
            if (cmd_tab[i][3]) e_ms = 1;
            else if (cmd_tab[i][2]) e_ms = 0;
            if (cmd_tab[i][1]) e_ls = 1;
            else if (cmd_tab[i][0]) e_ls = 0;
            @(negedge clk_i);
            check("store_en cmd", store_en_o, e_ms);
            check("newline_en cmd", newline_en_o, e_ls);
        end
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            proto_i <= proto_t'(i[1:0]);
            bus_active_i <= i[2];
            @(negedge clk_i);
            if (i[1:0] < 2) check("supply", bus_supply_select_o, i[1:0] == 0);
            check("pos drive", pos_bus_drive_o, i[2] && i[1:0] < 2);
            check("neg drive", neg_bus_drive_o, i[2] && i[1:0] == 1);
            check("k drive", kline_drive_o, i[2] && i[1:0] == 2);
            check("l drive", lline_drive_o, i[2] && i[1:0] == 2);
        end
        for (i = 0; i < 12; i++) begin
            @(posedge clk_i);
            w = $random(seed);
            {variable_pulse_rx_i, kline_rx_n_i, pwm_rx_n_i} <= w[2:0];
            {core_busy_i, tx_active_i, tx_bit_i} <= w[5:3];
            activity_i <= activity_t'(w[9:6]);
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            check("vpw rx", vpw_bus_active_o, w[2]);
            check("k rx", kline_bus_active_o, !w[1]);
            check("pwm rx", pwm_bus_active_o, !w[0]);
            check("busy", busy_o, w[5]);
            check("serial out", host_serial_out_o, w[4] ? w[3] : 1);
            check("indicators", indicator_n_o, 4'(~w[9:6]));
        end
        @(posedge clk_i);
        {core_busy_i, tx_active_i, bus_active_i} <= 3'h4;
        activity_i <= 4'h0;
        abort_cnt = 0;
        fork
            host_model_inst.attention(2, w);
            begin
                repeat (14) @(posedge clk_i);
                core_busy_i <= 1'b0;
            end
        join
        host_model_inst.send_char(8'h0D);
        repeat (4) @(negedge clk_i);
        check("host line idle", host_line, 1);
        check("abort pulses", abort_cnt, 1);
        check("rts held while busy", w >= 6, 1);
        rst_cnt = 0;
        @(posedge clk_i);
        master_clear_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        master_clear_n_i <= 1'b1;
        repeat (6) @(negedge clk_i);
        check("short clear", rst_cnt, 0);
        @(posedge clk_i);
        master_clear_n_i <= 1'b0;
        {baud_strap_i, memory_strap_i, line_end_strap_i} <= {e_bs, e_ms, e_ls};
        repeat (10) @(posedge clk_i);
        master_clear_n_i <= 1'b1;
        wait_ready();
        check("long clear", rst_cnt > 0, 1);
        check_straps();
        test_done();
    end

    initial begin
        repeat (4000) @(posedge clk_i);
        err_count++;
        test_done();
    end
endmodule
